/* File: hw/pfr_pkg.sv */
// shared constants and types of the power-fail and restart sequencer
package pfr_pkg;

  localparam int ADDR_W = 16;
  localparam int TMR_W = 27;

  // interrupt-memory word addresses, octal 040 and 042
  localparam logic [15:0] VEC_POWER_DOWN = 16'h0020;
  localparam logic [15:0] VEC_POWER_UP = 16'h0022;
  localparam logic [15:0] VEC_IDLE = 16'h0000;

  // clock rate
  localparam int CLK_MHZ = 125;

  // delays in their own units
  localparam int SERVICE_US = 160;
  localparam int MEM_OFF_US = 200;
  localparam int SETTLE_MS = 800;
  localparam int REG_SETTLE_MS = 70;
  localparam int GUARD_US = 100;

  // delays in clock cycles
  localparam int SERVICE_CYC = SERVICE_US * CLK_MHZ;
  localparam int MEM_OFF_CYC = MEM_OFF_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int REG_SETTLE_CYC = REG_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int GUARD_CYC = GUARD_US * CLK_MHZ;

  // values after reset
  localparam logic RST_POWER_STATUS = 1'b0;
  localparam logic [TMR_W-1:0] RST_COUNT = 27'h0000000;

  typedef enum logic [7:0] {
    ST_RUN = 8'h01,
    ST_PD_WAIT_EDGE = 8'h02,
    ST_PD_SERVICE = 8'h04,
    ST_PD_MEM_INHIBIT = 8'h08,
    ST_OFF = 8'h10,
    ST_PU_SETTLE = 8'h20,
    ST_PU_REG_SETTLE = 8'h40,
    ST_PU_GUARD = 8'h80
  } pfr_state_t;

endpackage : pfr_pkg

/* File: hw/pfr_tmr_if.sv */
// delay timer request and completion signals
`timescale 1ns/1ps
`default_nettype none
interface pfr_tmr_if;
  logic start;
  logic [pfr_pkg::TMR_W-1:0] load;
  logic done;
  modport seq (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : pfr_tmr_if
`default_nettype wire

/* File: hw/pfr_timer.sv */
// one-shot delay counter run from the free-running system clock
`timescale 1ns/1ps
`default_nettype none
module pfr_timer (
  input wire logic i_clock,   // system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  pfr_tmr_if.tmr tmr          // start, load and done
);

  logic [pfr_pkg::TMR_W-1:0] count;
  logic busy;

  // a load of n gives done n cycles after start
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      count <= pfr_pkg::RST_COUNT;
      busy <= 1'b0;
    end
    else if (tmr.start)
    begin
      count <= tmr.load - 27'h0000001;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (count == pfr_pkg::RST_COUNT)
        busy <= 1'b0;
      else
        count <= count - 27'h0000001;
    end
  end

  // done must not look at start: the sequencer raises start from done in the same cycle
  assign tmr.done = busy && (count == pfr_pkg::RST_COUNT);

endmodule : pfr_timer
`default_nettype wire

/* File: hw/pfr_sequencer.sv */
// power-fail and restart sequencer for processor and core memory control
`timescale 1ns/1ps
`default_nettype none
// Function
// - raise request at first interrupt clock fall
// - drive power-down vector while acknowledge held
// - allow at least 160 us service window
// - then disable memory and reset system
// - power-down finishes under 500 us
// - block lower-priority requests during service routine
// - sequencer holds highest interrupt priority
// - vectors at words 040 and 042
// - power-up loads 042, halts, clears, resets
// - hold reset 800 ms, then enable regulators
// - wait another 70 ms before releasing processor
// - drop reset and pulse start at 042
// - power-up completes under 1.1 seconds
// - ignore power-down for 100 us after start
// - finish power-down before starting power-up
// - sequences independent of outage length
// - protect memory even during single-step
// - power status clears at once, sets late
// - inhibit memory starts, then regulators off
module pfr_sequencer #(
  parameter int SERVICE_CYC = pfr_pkg::SERVICE_CYC,
  parameter int MEM_OFF_CYC = pfr_pkg::MEM_OFF_CYC,
  parameter int SETTLE_CYC = pfr_pkg::SETTLE_CYC,
  parameter int REG_SETTLE_CYC = pfr_pkg::REG_SETTLE_CYC,
  parameter int GUARD_CYC = pfr_pkg::GUARD_CYC
) (
  input wire logic i_clock,                           // system clock, 125 MHz
  input wire logic i_sys_rst,                         // synchronous reset, active high
  input wire logic i_power_good,                      // monitor: input power above threshold
  input wire logic i_int_clock,                       // processor interrupt clock
  input wire logic i_int_ack,                         // processor interrupt acknowledge
  output logic o_int_req,                             // power-down interrupt request
  output logic o_lower_inhibit,                       // block lower-priority requests
  output logic [pfr_pkg::ADDR_W-1:0] o_vector_data,   // vector onto internal data bus
  output logic o_vector_oe,                           // vector bus drive enable
  output logic o_load_restart,                        // load restart address into counter
  output logic [pfr_pkg::ADDR_W-1:0] o_restart_addr,  // restart address
  output logic o_force_halt,                          // force halt into instruction register
  output logic o_clear_work,                          // clear working register
  output logic o_sys_reset,                           // system reset to processor
  output logic o_start_pulse,                         // start pulse to processor
  output logic o_mem_reg_enable,                      // memory regulators enabled
  output logic o_mem_timing_reset,                    // memory timing control held reset
  output logic o_mem_start_inhibit,                   // memory-start clocks ignored
  output logic o_power_status                         // stored power status
);

  // delay loads sized to the timer
  localparam logic [pfr_pkg::TMR_W-1:0] LD_SERVICE = SERVICE_CYC[pfr_pkg::TMR_W-1:0];
  localparam logic [pfr_pkg::TMR_W-1:0] LD_MEM_OFF = MEM_OFF_CYC[pfr_pkg::TMR_W-1:0];
  localparam logic [pfr_pkg::TMR_W-1:0] LD_SETTLE = SETTLE_CYC[pfr_pkg::TMR_W-1:0];
  localparam logic [pfr_pkg::TMR_W-1:0] LD_REG_SETTLE = REG_SETTLE_CYC[pfr_pkg::TMR_W-1:0];
  localparam logic [pfr_pkg::TMR_W-1:0] LD_GUARD = GUARD_CYC[pfr_pkg::TMR_W-1:0];

  pfr_pkg::pfr_state_t state;
  pfr_pkg::pfr_state_t next_state;

  pfr_tmr_if tmr_bus ();

  pfr_timer u_timer (
    .i_clock (i_clock),
    .i_sys_rst (i_sys_rst),
    .tmr (tmr_bus.tmr)
  );

  // power-good synchroniser, first stage read only by the second
  logic pg_s1;
  logic pg_s2;
  logic pg_s3;
  logic pg_level;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      pg_s1 <= 1'b0;
      pg_s2 <= 1'b0;
      pg_s3 <= 1'b0;
    end
    else
    begin
      pg_s1 <= i_power_good;
      pg_s2 <= pg_s1;
      pg_s3 <= pg_s2;
    end
  end

  // filtered level moves only when the later stages agree
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      pg_level <= 1'b0;
    else if (pg_s2 == pg_s3)
      pg_level <= pg_s3;
  end

  // interrupt clock synchroniser and falling-edge detect
  logic ic_s1;
  logic ic_s2;
  logic ic_s3;
  logic ic_level;
  logic ic_fall;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      ic_s1 <= 1'b0;
      ic_s2 <= 1'b0;
      ic_s3 <= 1'b0;
      ic_level <= 1'b0;
    end
    else
    begin
      ic_s1 <= i_int_clock;
      ic_s2 <= ic_s1;
      ic_s3 <= ic_s2;
      if (ic_s2 == ic_s3)
        ic_level <= ic_s3;
    end
  end

  assign ic_fall = ic_level && (ic_s2 == ic_s3) && !ic_s3;

  // power failure seen by the running machine
  logic power_lost;
  assign power_lost = !pg_level;

  // sequencing; the same path is taken however long power was away
  always_comb
  begin
    next_state = state;
    tmr_bus.start = 1'b0;
    tmr_bus.load = LD_SERVICE;
    case (state)
      pfr_pkg::ST_RUN:
      begin
        // stepping does not change the path
        if (power_lost)
          next_state = pfr_pkg::ST_PD_WAIT_EDGE;
      end
      pfr_pkg::ST_PD_WAIT_EDGE:
      begin
        if (ic_fall)
        begin
          next_state = pfr_pkg::ST_PD_SERVICE;
          tmr_bus.start = 1'b1;
          tmr_bus.load = LD_SERVICE;
        end
      end
      pfr_pkg::ST_PD_SERVICE:
      begin
        // power return is ignored until power-down is done
        if (tmr_bus.done)
        begin
          next_state = pfr_pkg::ST_PD_MEM_INHIBIT;
          tmr_bus.start = 1'b1;
          tmr_bus.load = LD_MEM_OFF;
        end
      end
      pfr_pkg::ST_PD_MEM_INHIBIT:
      begin
        if (tmr_bus.done)
          next_state = pfr_pkg::ST_OFF;
      end
      pfr_pkg::ST_OFF:
      begin
        if (pg_level)
        begin
          next_state = pfr_pkg::ST_PU_SETTLE;
          tmr_bus.start = 1'b1;
          tmr_bus.load = LD_SETTLE;
        end
      end
      pfr_pkg::ST_PU_SETTLE:
      begin
        if (power_lost)
          next_state = pfr_pkg::ST_OFF;
        else if (tmr_bus.done)
        begin
          next_state = pfr_pkg::ST_PU_REG_SETTLE;
          tmr_bus.start = 1'b1;
          tmr_bus.load = LD_REG_SETTLE;
        end
      end
      pfr_pkg::ST_PU_REG_SETTLE:
      begin
        if (power_lost)
          next_state = pfr_pkg::ST_OFF;
        else if (tmr_bus.done)
        begin
          next_state = pfr_pkg::ST_PU_GUARD;
          tmr_bus.start = 1'b1;
          tmr_bus.load = LD_GUARD;
        end
      end
      pfr_pkg::ST_PU_GUARD:
      begin
        // power loss is not looked at here
        if (tmr_bus.done)
          next_state = pfr_pkg::ST_RUN;
      end
      default:
      begin
        next_state = pfr_pkg::ST_OFF;
      end
    endcase
  end

  // state register; after reset the machine waits for power
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      state <= pfr_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // interrupt request, raised on the clock fall, dropped on acknowledge
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      o_int_req <= 1'b0;
    else if (state == pfr_pkg::ST_PD_WAIT_EDGE && ic_fall)
      o_int_req <= 1'b1;
    else if (i_int_ack || state != pfr_pkg::ST_PD_SERVICE)
      o_int_req <= 1'b0;
  end

  // lower-priority requesters held off from detection to shutdown
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      o_lower_inhibit <= 1'b0;
    else
      o_lower_inhibit <= (next_state == pfr_pkg::ST_PD_WAIT_EDGE) ||
                         (next_state == pfr_pkg::ST_PD_SERVICE) ||
                         (next_state == pfr_pkg::ST_PD_MEM_INHIBIT);
  end

  // power-down vector on the bus for as long as acknowledge stays
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_vector_oe <= 1'b0;
      o_vector_data <= pfr_pkg::VEC_IDLE;
    end
    else if (i_int_ack && state == pfr_pkg::ST_PD_SERVICE)
    begin
      o_vector_oe <= 1'b1;
      o_vector_data <= pfr_pkg::VEC_POWER_DOWN;
    end
    else
    begin
      o_vector_oe <= 1'b0;
      o_vector_data <= pfr_pkg::VEC_IDLE;
    end
  end

  // restart preset to the processor during the 800 ms settle only, while reset is held
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_load_restart <= 1'b0;
      o_restart_addr <= pfr_pkg::VEC_IDLE;
      o_force_halt <= 1'b0;
      o_clear_work <= 1'b0;
    end
    else
    begin
      o_load_restart <= (next_state == pfr_pkg::ST_PU_SETTLE);
      o_restart_addr <= pfr_pkg::VEC_POWER_UP;
      o_force_halt <= (next_state == pfr_pkg::ST_PU_SETTLE);
      o_clear_work <= (next_state == pfr_pkg::ST_PU_SETTLE);
    end
  end

  // system reset and the start pulse that ends it
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_sys_reset <= 1'b1;
      o_start_pulse <= 1'b0;
    end
    else
    begin
      o_sys_reset <= (next_state == pfr_pkg::ST_OFF) ||
                     (next_state == pfr_pkg::ST_PU_SETTLE) ||
                     (next_state == pfr_pkg::ST_PU_REG_SETTLE);
      o_start_pulse <= (state == pfr_pkg::ST_PU_REG_SETTLE) &&
                       (next_state == pfr_pkg::ST_PU_GUARD);
    end
  end

  // core memory controls
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_mem_reg_enable <= 1'b0;
      o_mem_timing_reset <= 1'b1;
      o_mem_start_inhibit <= 1'b1;
    end
    else
    begin
      o_mem_reg_enable <= (next_state != pfr_pkg::ST_OFF) &&
                          (next_state != pfr_pkg::ST_PU_SETTLE);
      o_mem_timing_reset <= (next_state == pfr_pkg::ST_OFF) ||
                            (next_state == pfr_pkg::ST_PU_SETTLE);
      o_mem_start_inhibit <= (next_state == pfr_pkg::ST_PD_MEM_INHIBIT) ||
                             (next_state == pfr_pkg::ST_OFF) ||
                             (next_state == pfr_pkg::ST_PU_SETTLE) ||
                             (next_state == pfr_pkg::ST_PU_REG_SETTLE);
    end
  end

  // stored power status: cleared on detection, set after the long delay
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      o_power_status <= pfr_pkg::RST_POWER_STATUS;
    else if (state == pfr_pkg::ST_PU_SETTLE && next_state == pfr_pkg::ST_PU_REG_SETTLE)
      o_power_status <= 1'b1;
    else if (next_state == pfr_pkg::ST_PD_WAIT_EDGE || next_state == pfr_pkg::ST_OFF)
      o_power_status <= 1'b0;
  end

  // the sums of the delays keep both sequences inside their limits

endmodule : pfr_sequencer
`default_nettype wire

/* File: sim/pfr_seq_properties.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pfr_seq_checker (
  input wire logic i_clock,                                  // clock
  input wire logic i_sys_rst,                                // reset
  input wire logic i_int_clock,                              // interrupt clock
  input wire logic i_int_ack,                                // acknowledge
  input wire logic o_int_req,                                // request
  input wire logic o_lower_inhibit,                          // lower block
  input wire logic [pfr_pkg::ADDR_W-1:0] o_vector_data,      // vector
  input wire logic o_vector_oe,                              // vector enable
  input wire logic o_load_restart,                           // load restart
  input wire logic [pfr_pkg::ADDR_W-1:0] o_restart_addr,     // restart address
  input wire logic o_force_halt,                             // halt
  input wire logic o_clear_work,                             // clear
  input wire logic o_sys_reset,                              // system reset
  input wire logic o_start_pulse,                            // start
  input wire logic o_mem_reg_enable,                         // regulators
  input wire logic o_mem_timing_reset,                       // timing reset
  input wire logic o_mem_start_inhibit,                      // start inhibit
  input wire logic o_power_status                            // power status
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] since_fall;
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      since_fall <= 8'hff;
    else if ($fell(i_int_clock))
      since_fall <= 8'h00;
    else if (since_fall != 8'hff)
      since_fall <= since_fall + 8'h01;
  end
  sequence s_pulse_gone;
    !o_start_pulse;
  endsequence
  property p_req_edge;
    $rose(o_int_req) |-> since_fall inside {[8'h02:8'h0c]};
  endproperty
  property p_vec;
    o_vector_oe |-> o_vector_data == pfr_pkg::VEC_POWER_DOWN && $past(i_int_ack);
  endproperty
  property p_vec_off;
    !i_int_ack |=> !o_vector_oe;
  endproperty
  property p_inhibit;
    o_int_req |-> o_lower_inhibit;
  endproperty
  property p_mem_off;
    $rose(o_sys_reset) |-> !o_mem_reg_enable && o_mem_timing_reset && o_mem_start_inhibit;
  endproperty
  property p_restart;
    o_load_restart |-> o_restart_addr == pfr_pkg::VEC_POWER_UP && o_force_halt && o_clear_work
      && o_sys_reset;
  endproperty
  property p_start;
    o_start_pulse |-> !o_sys_reset && $past(o_sys_reset) ##1 s_pulse_gone;
  endproperty
  property p_status;
    $rose(o_power_status) |-> $rose(o_mem_reg_enable) && !o_mem_timing_reset;
  endproperty
  a_req_edge: assert property (p_req_edge) else $error("request off clock fall");
  a_vec: assert property (p_vec) else $error("vector wrong");
  a_vec_off: assert property (p_vec_off) else $error("vector held");
  a_inhibit: assert property (p_inhibit) else $error("lower not blocked");
  a_mem_off: assert property (p_mem_off) else $error("memory not off");
  a_restart: assert property (p_restart) else $error("restart preset wrong");
  a_start: assert property (p_start) else $error("start pulse wrong");
  a_status: assert property (p_status) else $error("status set early");
endmodule : pfr_seq_checker
bind pfr_sequencer pfr_seq_checker i_pfr_seq_checker (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_int_clock(i_int_clock),
  .i_int_ack(i_int_ack), .o_int_req(o_int_req), .o_lower_inhibit(o_lower_inhibit),
  .o_vector_data(o_vector_data), .o_vector_oe(o_vector_oe), .o_load_restart(o_load_restart),
  .o_restart_addr(o_restart_addr), .o_force_halt(o_force_halt), .o_clear_work(o_clear_work),
  .o_sys_reset(o_sys_reset), .o_start_pulse(o_start_pulse),
  .o_mem_reg_enable(o_mem_reg_enable), .o_mem_timing_reset(o_mem_timing_reset),
  .o_mem_start_inhibit(o_mem_start_inhibit), .o_power_status(o_power_status));
`default_nettype wire

/* File: sim/pfr_cpu_model.sv */
// processor interrupt side: interrupt clock and acknowledge
`timescale 1ns/1ps
`default_nettype none
module pfr_cpu_model (
  input wire logic i_clock,      // system clock
  input wire logic i_sys_rst,    // reset
  input wire logic i_int_req,    // request from sequencer
  input wire logic [2:0] i_lag,  // cycles before acknowledge
  output logic o_int_clock,      // free-running interrupt clock
  output var logic o_int_ack     // acknowledge
);
  logic [4:0] div;
  logic [2:0] wt;
  logic [2:0] hold;
  assign o_int_clock = div[4];
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      div <= 5'h00;
      wt <= 3'h0;
      hold <= 3'h0;
      o_int_ack <= 1'b0;
    end
    else
    begin
      div <= div + 5'h01;
      // request only taken at an instruction end, lag cycles later
      if (hold != 3'h0)
      begin
        hold <= hold - 3'h1;
        if (hold == 3'h1)
          o_int_ack <= 1'b0;
      end
      else if (i_int_req && wt == i_lag)
      begin
        o_int_ack <= 1'b1;
        hold <= 3'h4; // routine ends well inside the window
        wt <= 3'h0;
      end
      else if (i_int_req)
        wt <= wt + 3'h1;
    end
  end
endmodule : pfr_cpu_model
`default_nettype wire

/* File: sim/power_fail_restart_sequencer_tb.sv */
// self-checking bench for the power-fail and restart sequencer
`timescale 1ns/1ps
`default_nettype none
module power_fail_restart_sequencer_tb;
  localparam int SRV = 20;
  localparam int MOF = 25;
  localparam int SET = 100;
  localparam int REG = 40;
  logic i_clock = 1'b0;
  logic i_sys_rst, i_power_good, ic, ack, req, linh, oe, ldr, halt_instruction, clw, srst, stp;
  logic rge, trst, msi, pst;
  logic [2:0] lag;
  logic [15:0] vdat, radr;
  logic [5:0] nv, prv = 6'h00;
  logic ps, saw_oe;
  int fails = 0, n_compared = 0, cyc = 0, it, tf, tsf, out, r, seed = 32'hacd7;
  int t[6];
  pfr_sequencer #(.SERVICE_CYC(SRV), .MEM_OFF_CYC(MOF), .SETTLE_CYC(SET),
    .REG_SETTLE_CYC(REG), .GUARD_CYC(15)) i_pfr_sequencer (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_power_good(i_power_good),
    .i_int_clock(ic), .i_int_ack(ack), .o_int_req(req), .o_lower_inhibit(linh),
    .o_vector_data(vdat), .o_vector_oe(oe), .o_load_restart(ldr), .o_restart_addr(radr),
    .o_force_halt(halt_instruction), .o_clear_work(clw), .o_sys_reset(srst), .o_start_pulse(stp),
    .o_mem_reg_enable(rge), .o_mem_timing_reset(trst), .o_mem_start_inhibit(msi),
    .o_power_status(pst));
  pfr_cpu_model i_pfr_cpu_model (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_int_req(req), .i_lag(lag), .o_int_clock(ic), .o_int_ack(ack));
  initial forever #4 i_clock = ~i_clock;
  always @(negedge i_clock) cyc++;
  // event stamps: start, regulators, load, off, inhibit, request
  always @(posedge i_clock)
  begin
    nv = {req, msi, srst, ldr, rge, stp};
    for (int k = 0; k < 6; k++)
      if (nv[k] === 1'b1 && prv[k] !== 1'b1)
        t[k] = cyc;
    if (pst === 1'b0 && ps === 1'b1)
      tsf = cyc;
    if (oe === 1'b1)
    begin
      saw_oe = 1'b1;
      check(32'(vdat), 32'(pfr_pkg::VEC_POWER_DOWN), "vector_data");
    end
    prv = nv;
    ps = pst;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task rng(input int d, input int lo, input int hi, input string what);
    check(32'(d >= lo && d <= hi), 32'h1, what);
  endtask : rng
  task wait_start;
    int n;
    n = 0;
    while (stp !== 1'b1 && n < 3000)
    begin
      @(posedge i_clock);
      n++;
    end
    check(32'(stp), 32'h1, "start_pulse");
  endtask : wait_start
  task pu_checks;
    @(posedge i_clock);
    rng(t[1] - t[2], SET, SET + 2, "settle");
    rng(t[0] - t[1], REG, REG + 2, "reg_settle");
    check(32'(pst), 32'h1, "power_status");
    check(32'({srst, msi}), 32'h0, "sys_reset");
    check(32'(radr), 32'(pfr_pkg::VEC_POWER_UP), "restart_addr");
  endtask : pu_checks
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial
  begin
    #(8 * 9000);
    fails++;
    complete_run;
  end
  initial
  begin
    i_sys_rst = 1'b1;
    i_power_good = 1'b1;
    lag = 3'h0;
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    wait_start;
    pu_checks;
    for (it = 0; it < 4; it++)
    begin
      lag <= 3'($random(seed));
      saw_oe = 1'b0;
      repeat (40) @(posedge i_clock);
      i_power_good <= 1'b0;
      tf = cyc;
      out = 10 + ($random(seed) & 255);
      repeat (out) @(posedge i_clock);
      i_power_good <= 1'b1;
      wait_start;
      pu_checks;
      rng(t[5] - tf, 6, 48, "request");
      rng(t[4] - t[5], SRV, SRV + 2, "service");
      rng(t[3] - t[4], MOF, MOF + 2, "mem_off");
      rng(tsf - tf, 3, 9, "status_clear");
      check(32'(saw_oe), 32'h1, "vector_oe");
      check(32'(t[2] > t[3]), 32'h1, "order");
      // short dip right after the start pulse
      repeat (2) @(posedge i_clock);
      i_power_good <= 1'b0;
      repeat (6) @(posedge i_clock);
      i_power_good <= 1'b1;
      r = t[5];
      repeat (60) @(posedge i_clock); // restore routine runs in this quiet span
      check(t[5], r, "guard_request");
      check(32'(linh), 32'h0, "guard_inhibit");
    end
    // power lost again during the long settle: back to off, then a full settle
    i_power_good <= 1'b0;
    repeat (130) @(posedge i_clock);
    i_power_good <= 1'b1;
    repeat (40) @(posedge i_clock);
    i_power_good <= 1'b0;
    repeat (8) @(posedge i_clock);
    check(32'({ldr, srst, pst}), 32'h2, "settle_abort");
    i_power_good <= 1'b1;
    wait_start;
    pu_checks;
    complete_run;
  end
endmodule : power_fail_restart_sequencer_tb
`default_nettype wire
